// File: hw/resolver_converter_config_regs.sv
`timescale 1ns/10ps
`include "resolver_cfg_map.svh"
// Operation
// - excitation frequency register at 0x91 holds a seven-bit word in low bits.
// - excitation frequency equals word times clock divided by two to fifteen.
// - after reset the frequency word gives 10 kHz excitation.
// - control register at 0x92 resets to 0x7e.
// - control bit 5 picks lock range: 0 is 360 degrees, 1 is 44.
// - one LSB hysteresis between position integrator and position register.
// - control bit 4 enables hysteresis, enabled after reset.
// - control bits 3 and 2 select encoder resolution 10/12/14/16.
// - encoder outputs run at 16 bits after reset.
// - output resolution from control bits in config mode, else from pins.
// - position and velocity run at 12 bits after reset in config mode.
// - written byte with bit 7 high is an address, low is data.
// - data write stores a parity bit over bits 6..0 in bit 7.
// - readback of 0x91 and 0x92 recomputes parity and returns bit 7 high on mismatch.
// - address 0xf0 in config mode starts a software reset, no data.
// - software reset keeps config, clears faults, restarts excitation phase.
// - fault register at 0xff; any fault drives a fault pin low.
// - fault bits active high, clip down to parity error.
// - registers writable over the parallel or the four-wire serial port.
// - config mode when both mode selects high; writes and parallel reads need it, serial readback does not.
// - parallel write latches address then data on write strobe rising edges.
// - first sample falling edge after fault read clears fault pins.
module resolver_converter_config_regs
	import resolver_cfg_pkg::*;
(
	input wire logic clk, // converter clock
	input wire logic reset, // synchronous, active high
	input wire logic mode_sel_0, // mode select 0
	input wire logic mode_sel_1, // mode select 1
	input wire logic cs_n, // chip select
	input wire logic rd_n, // read strobe
	input wire logic write_strobe_frame_sync, // write strobe / frame sync, low active
	input wire logic soe_n, // high: parallel, low: serial
	input wire logic sample_n, // sample strobe
	input wire logic [7:0] db_in, // data bus pins in
	output logic [7:0] db_out, // data bus pins out
	output logic db_oe_n, // low while driving the bus
	input wire logic sclk, // serial clock
	input wire logic sdi, // serial data in
	output logic sdo, // serial data out
	input wire logic out_res_sel_lo, // resolution pin, low bit
	input wire logic out_res_sel_hi, // resolution pin, high bit
	input wire fault_in_s fault_in, // detector levels
	input wire logic [15:0] pos_in, // position integrator output
	output logic [15:0] pos_hyst, // position register input
	output loop_cfg_s loop_cfg, // loop and generator settings
	output logic [`EXC_ACC_BITS-1:0] exc_phase, // excitation phase accumulator
	output logic loop_restart, // one-cycle restart pulse
	output logic signal_degrade_flag_n, // low on signal fault
	output logic tracking_loss_flag_n // low on tracking fault
);

	logic [7:0] exc_freq_word;
	logic [7:0] control_settings;
	logic [7:0] fault_flags;
	logic [7:0] addr_reg;
	logic [7:0] read_value;
	logic config_mode;
	logic wr_prev;
	logic sclk_prev;
	logic rd_prev;
	logic sample_prev;
	logic par_wr;
	logic ser_byte;
	logic [7:0] wr_byte;
	logic wr_valid;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic [3:0] bit_count;
	logic read_access;
	logic ser_fsync_fall;
	logic parity_bad;
	logic soft_reset;
	logic fault_read_seen;
	logic sample_fall;
	logic [7:0] fault_set;
	logic clear_flags;
	res_e next_out_res;

	assign config_mode = mode_sel_0 & mode_sel_1;

	// parallel write edge, rising edge of the strobe with chip selected
	assign par_wr = soe_n & ~cs_n & write_strobe_frame_sync & ~wr_prev;
	assign ser_fsync_fall = ~soe_n & ~write_strobe_frame_sync & wr_prev;
	assign wr_byte = par_wr ? db_in : {shift_in[6:0], sdi};
	assign wr_valid = config_mode & (par_wr | ser_byte);

	// a serial byte completes on the eighth falling clock edge in a frame
	assign ser_byte = ~soe_n & ~write_strobe_frame_sync & sclk_prev & ~sclk
		& (bit_count == `SERIAL_BITS - 4'h1);

	// a read access is a parallel read start or a serial frame start
	assign read_access = config_mode & ((soe_n & ~cs_n & ~rd_n & rd_prev) | ser_fsync_fall);

	assign soft_reset = wr_valid & (wr_byte == `ADDR_SOFT_RESET);
	assign sample_fall = sample_prev & ~sample_n;

	// edge history; inputs are synchronous so no synchroniser is needed
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_prev <= 1'b1;
			sclk_prev <= 1'b0;
			rd_prev <= 1'b1;
			sample_prev <= 1'b1;
		end else begin
			wr_prev <= write_strobe_frame_sync;
			sclk_prev <= sclk;
			rd_prev <= rd_n;
			sample_prev <= sample_n;
		end
	end

	// serial shift in on falling clock edges, msb first
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_in <= 8'h00;
			bit_count <= 4'h0;
		end else if (soe_n | write_strobe_frame_sync) begin
			bit_count <= 4'h0; // frame ends clear a partial byte
		end else if (sclk_prev & ~sclk) begin
			shift_in <= {shift_in[6:0], sdi};
			bit_count <= ser_byte ? 4'h0 : bit_count + 4'h1;
		end
	end

	// address latch; the last address stays valid across mode changes
	always_ff @(posedge clk) begin
		if (reset) begin
			addr_reg <= `ADDR_FAULT;
		end else if (wr_valid & wr_byte[`BIT_ADDR_FLAG]) begin
			addr_reg <= wr_byte;
		end
	end

	// data bytes land in the addressed register with even parity in bit 7
	always_ff @(posedge clk) begin
		if (reset) begin
			exc_freq_word <= {1'b0, `RST_FCW};
			control_settings <= `RST_CONTROL;
		end else if (wr_valid & ~wr_byte[`BIT_ADDR_FLAG]) begin
			if (addr_reg == `ADDR_EXC_FREQ) begin
				exc_freq_word <= {^wr_byte[6:0], wr_byte[6:0]};
			end else if (addr_reg == `ADDR_CONTROL) begin
				control_settings <= {^wr_byte[6:0], wr_byte[6:0]};
			end
		end
	end

	// readback value; parity checked on the read/write registers only
	always_comb begin
		parity_bad = 1'b0;
		if (addr_reg == `ADDR_EXC_FREQ) begin
			parity_bad = exc_freq_word[`BIT_PARITY] != ^exc_freq_word[6:0];
			read_value = {parity_bad, exc_freq_word[6:0]};
		end else if (addr_reg == `ADDR_CONTROL) begin
			parity_bad = control_settings[`BIT_PARITY] != ^control_settings[6:0];
			read_value = {parity_bad, control_settings[6:0]};
		end else if (addr_reg == `ADDR_FAULT) begin
			read_value = fault_flags;
		end else begin
			read_value = 8'h00;
		end
	end

	// parallel bus drive, only while selected and reading in config mode
	always_ff @(posedge clk) begin
		if (reset) begin
			db_out <= 8'h00;
			db_oe_n <= 1'b1;
		end else begin
			db_out <= read_value;
			db_oe_n <= ~(soe_n & ~cs_n & ~rd_n & config_mode);
		end
	end

	// serial out: loaded at frame start, shifted on falling clock edges
	always_ff @(posedge clk) begin
		if (reset) begin
			shift_out <= 8'h00;
			sdo <= 1'b0;
		end else if (ser_fsync_fall) begin
			shift_out <= read_value;
			sdo <= read_value[7];
		end else if (~soe_n & ~write_strobe_frame_sync & sclk_prev & ~sclk) begin
			shift_out <= {shift_out[6:0], 1'b0};
			sdo <= shift_out[6];
		end
	end

	// fault events; parity mismatch seen on readback feeds bit 0
	always_comb begin
		fault_set = 8'h00;
		fault_set[`FLT_CLIP] = fault_in.clip;
		fault_set[`FLT_LOSS] = fault_in.signal_loss;
		fault_set[`FLT_OVERRANGE] = fault_in.overrange;
		fault_set[`FLT_MISMATCH] = fault_in.mismatch;
		fault_set[`FLT_TRACK] = fault_in.track;
		fault_set[`FLT_VELOCITY] = fault_in.velocity;
		fault_set[`FLT_PHASE] = fault_in.phase;
		fault_set[`FLT_PARITY] = read_access & parity_bad;
	end

	// clear on the sample edge after a fault read, or on software reset
	assign clear_flags = (sample_fall & fault_read_seen) | soft_reset;

	// sticky flags; a new event in the clearing cycle still sets its bit
	always_ff @(posedge clk) begin
		if (reset) begin
			fault_flags <= 8'h00;
		end else begin
			fault_flags <= (clear_flags ? 8'h00 : fault_flags) | fault_set;
		end
	end

	// remember that the fault register was read since the last sample edge
	always_ff @(posedge clk) begin
		if (reset) begin
			fault_read_seen <= 1'b0;
		end else if (read_access & (addr_reg == `ADDR_FAULT)) begin
			fault_read_seen <= 1'b1;
		end else if (sample_fall | soft_reset) begin
			fault_read_seen <= 1'b0;
		end
	end

	// fault pins, low active; signal faults on one pin, tracking on the other
	always_ff @(posedge clk) begin
		if (reset) begin
			signal_degrade_flag_n <= 1'b1;
			tracking_loss_flag_n <= 1'b1;
		end else begin
			signal_degrade_flag_n <= ~(|fault_flags[7:4]);
			tracking_loss_flag_n <= ~(|fault_flags[3:0]);
		end
	end

	// output resolution: control bits in config mode, pins otherwise
	always_comb begin
		if (config_mode) begin
			next_out_res = res_e'({control_settings[`CTL_RES_LO],
				control_settings[`CTL_RES_HI]});
		end else begin
			next_out_res = res_e'({out_res_sel_lo, out_res_sel_hi});
		end
	end

	// settings to the loop, registered so outputs come from flip-flops
	always_ff @(posedge clk) begin
		if (reset) begin
			loop_cfg.freq_control_word <= `RST_FCW;
			loop_cfg.lock_range_narrow <= 1'(`RST_CONTROL >> `CTL_LOCK_RANGE);
			loop_cfg.hyst_en <= 1'(`RST_CONTROL >> `CTL_HYST_EN);
			loop_cfg.enc_res <= RES_16;
			loop_cfg.out_res <= RES_12;
		end else begin
			loop_cfg.freq_control_word <= exc_freq_word[6:0];
			loop_cfg.lock_range_narrow <= control_settings[`CTL_LOCK_RANGE];
			loop_cfg.hyst_en <= control_settings[`CTL_HYST_EN];
			loop_cfg.enc_res <= res_e'({control_settings[`CTL_ENC_LO],
				control_settings[`CTL_ENC_HI]});
			loop_cfg.out_res <= next_out_res;
		end
	end

	// phase accumulator; wraps every 2^15/word clocks, restart keeps parts aligned
	always_ff @(posedge clk) begin
		if (reset | soft_reset) begin
			exc_phase <= '0;
		end else begin
			exc_phase <= exc_phase + {8'h00, exc_freq_word[6:0]};
		end
	end

	// one-cycle restart to the tracking loop
	always_ff @(posedge clk) begin
		if (reset) begin
			loop_restart <= 1'b0;
		end else begin
			loop_restart <= soft_reset;
		end
	end

	// weight of one output lsb at the given resolution
	function automatic logic [15:0] lsb_step(input res_e r);
		case (r)
			RES_10: lsb_step = 16'h0040;
			RES_12: lsb_step = 16'h0010;
			RES_14: lsb_step = 16'h0004;
			default: lsb_step = 16'h0001;
		endcase
	endfunction

	logic [15:0] step;
	logic [15:0] pos_diff;
	logic [15:0] pos_mag;
	assign step = lsb_step(loop_cfg.out_res);
	assign pos_diff = pos_in - pos_hyst;
	assign pos_mag = pos_diff[15] ? 16'h0000 - pos_diff : pos_diff;

	// hysteresis: move only on more than one lsb, low bits zeroed when on
	always_ff @(posedge clk) begin
		if (reset) begin
			pos_hyst <= 16'h0000;
		end else if (!loop_cfg.hyst_en) begin
			pos_hyst <= pos_in;
		end else if (pos_mag > step) begin
			pos_hyst <= pos_in & ~(step - 16'h0001);
		end
	end

endmodule

// File: common/resolver_cfg_map.svh
`ifndef RESOLVER_CFG_MAP_SVH
`define RESOLVER_CFG_MAP_SVH

// register addresses, all with the address flag set
`define ADDR_EXC_FREQ 8'h91
`define ADDR_CONTROL 8'h92
`define ADDR_SOFT_RESET 8'hf0
`define ADDR_FAULT 8'hff

// byte layout
`define BIT_ADDR_FLAG 7
`define BIT_PARITY 7

// control field positions
`define CTL_LOCK_RANGE 5
`define CTL_HYST_EN 4
`define CTL_ENC_HI 3
`define CTL_ENC_LO 2
`define CTL_RES_HI 1
`define CTL_RES_LO 0

// fault bit positions
`define FLT_CLIP 7
`define FLT_LOSS 6
`define FLT_OVERRANGE 5
`define FLT_MISMATCH 4
`define FLT_TRACK 3
`define FLT_VELOCITY 2
`define FLT_PHASE 1
`define FLT_PARITY 0

// reset values; freq word assumes an 8.192 MHz converter clock for 10 kHz
`define RST_CONTROL 8'h7e
`define RST_FCW 7'h28
`define EXC_ACC_BITS 15
`define SERIAL_BITS 4'h8

`endif

// File: common/resolver_cfg_pkg.sv
package resolver_cfg_pkg;

	// resolution codes, index formed as {sel_lo, sel_hi}
	typedef enum logic [1:0] {
		RES_10,
		RES_12,
		RES_14,
		RES_16
	} res_e;

	// configuration handed to the tracking loop and excitation generator
	typedef struct packed {
		logic [6:0] freq_control_word;
		logic lock_range_narrow;
		logic hyst_en;
		res_e enc_res;
		res_e out_res;
	} loop_cfg_s;

	// raw fault detector levels, fault register bit 0 is generated in the register block
	typedef struct packed {
		logic clip;
		logic signal_loss;
		logic overrange;
		logic mismatch;
		logic track;
		logic velocity;
		logic phase;
	} fault_in_s;

endpackage

// File: test/cfg_regs_assertions.sv
`timescale 1ns/10ps
`include "resolver_cfg_map.svh"
module cfg_regs_checker
	import resolver_cfg_pkg::*;
(
	input wire logic clk, // clock
	input wire logic reset, // reset
	input wire logic mode_sel_0, // mode
	input wire logic mode_sel_1, // mode
	input wire logic cs_n, // select
	input wire logic rd_n, // read
	input wire logic soe_n, // port
	input wire logic out_res_sel_lo, // pin
	input wire logic out_res_sel_hi, // pin
	input wire fault_in_s fault_in, // faults
	input wire logic db_oe_n, // enable
	input wire loop_cfg_s loop_cfg, // settings
	input wire logic [`EXC_ACC_BITS-1:0] exc_phase, // phase
	input wire logic loop_restart, // restart
	input wire logic signal_degrade_flag_n, // pin
	input wire logic tracking_loss_flag_n // pin
);
	// settings lag the registers, so windows span a few cycles
	wire logic cfg = mode_sel_0 & mode_sel_1;
	wire logic [1:0] pins = {out_res_sel_lo, out_res_sel_hi};
	wire logic rd_on = !cs_n && !rd_n && soe_n && cfg;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	// settings, phase and restart
	property p_rst_cfg; $fell(reset) |-> loop_cfg == {`RST_FCW, 2'b11, RES_16, RES_12}; endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("reset settings");
	// the accumulator was cleared by reset, so skip the first edge after release
	property p_phase; $stable(loop_cfg.freq_control_word)[*2] ##0 !loop_restart
		##0 !$past(reset) |->
		exc_phase == `EXC_ACC_BITS'($past(exc_phase) + $past(loop_cfg.freq_control_word)); endproperty
	a_phase: assert property (p_phase) else $error("phase step");
	property p_rst_phase; $rose(loop_restart) |-> exc_phase == '0; endproperty
	a_rst_phase: assert property (p_rst_phase) else $error("phase restart");
	property p_pulse; loop_restart |=> !loop_restart; endproperty
	a_pulse: assert property (p_pulse) else $error("restart width");
	// fault pins, bus enable and resolution pins
	property p_degrade; |fault_in[6:3] |-> ##[1:3] !signal_degrade_flag_n; endproperty
	a_degrade: assert property (p_degrade) else $error("degrade pin");
	property p_track; |fault_in[2:0] |-> ##[1:3] !tracking_loss_flag_n; endproperty
	a_track: assert property (p_track) else $error("tracking pin");
	property p_oe_on; rd_on [*2] |-> !db_oe_n; endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus not driven");
	property p_pins; (!cfg && $stable(pins)) [*3] |-> loop_cfg.out_res == res_e'(pins); endproperty
	a_pins: assert property (p_pins) else $error("pin resolution");
	c_restart: cover property ($rose(loop_restart));
	c_degrade: cover property ($fell(signal_degrade_flag_n));
	c_read: cover property (rd_on ##1 !db_oe_n);
endmodule

// File: test/host_port_model.sv
`timescale 1ns/10ps
module host_port_model (
	input wire logic clk, // clock
	input wire logic [7:0] db_out, // readback
	input wire logic sdo, // serial readback
	output logic cs_n, // select
	output logic rd_n, // read
	output logic write_strobe_frame_sync, // write
	output logic [7:0] db_in, // bus
	output logic mode_sel_0, // mode
	output logic mode_sel_1, // mode
	output logic soe_n, // port select
	output logic sclk, // serial clock
	output logic sdi // serial data
);
	// idle levels; bus carries junk when not written
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		write_strobe_frame_sync = 1'b1;
		db_in = 8'h55;
		mode_sel_0 = 1'b0;
		mode_sel_1 = 1'b0;
		soe_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// pick the port; the strobe idles high so no false frame edge
	task port(input logic serial);
		@(posedge clk);
		soe_n <= ~serial;
	endtask
	// one framed byte, msb first; clock idles low outside the frame
	task xfer(input logic [7:0] b, output logic [7:0] r);
		@(posedge clk);
		write_strobe_frame_sync <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			sclk <= 1'b1;
			sdi <= b[i];
			@(posedge clk);
			r[i] = sdo; // settled since the previous falling clock
			sclk <= 1'b0;
			@(posedge clk);
		end
		write_strobe_frame_sync <= 1'b1;
	endtask
	// both selects high for configuration
	task mode(input logic on);
		@(posedge clk);
		mode_sel_0 <= on;
		mode_sel_1 <= on;
	endtask
	// one byte per strobe rise; bit 7 marks an address
	task put(input logic [7:0] b);
		@(posedge clk);
		cs_n <= 1'b0;
		write_strobe_frame_sync <= 1'b0;
		db_in <= b;
		@(posedge clk);
		write_strobe_frame_sync <= 1'b1;
		@(posedge clk);
		cs_n <= 1'b1;
		db_in <= ~b;
	endtask
	// address first, then hold read low until enable has landed
	task get(input logic [7:0] a, output logic [7:0] d);
		put(a);
		@(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (2) @(posedge clk);
		d = db_out;
		rd_n <= 1'b1;
		cs_n <= 1'b1;
	endtask
endmodule

// File: test/test_resolver_converter_config_regs.sv
`timescale 1ns/10ps
`include "resolver_cfg_map.svh"
bind resolver_converter_config_regs cfg_regs_checker chk_i (.clk, .reset, .mode_sel_0,
	.mode_sel_1, .cs_n, .rd_n, .soe_n, .out_res_sel_lo, .out_res_sel_hi, .fault_in, .db_oe_n,
	.loop_cfg, .exc_phase, .loop_restart, .signal_degrade_flag_n, .tracking_loss_flag_n);
module test_resolver_converter_config_regs
	import resolver_cfg_pkg::*;
;
	logic clk, reset, cs_n, rd_n, write_strobe_frame_sync, sample_n, db_oe_n, loop_restart;
	logic mode_sel_0, mode_sel_1, out_res_sel_lo, out_res_sel_hi;
	logic signal_degrade_flag_n, tracking_loss_flag_n;
	logic soe_n, sclk, sdi, sdo;
	logic [7:0] db_in, db_out, d, v;
	logic [15:0] pos_in, pos_hyst;
	logic [`EXC_ACC_BITS-1:0] exc_phase;
	fault_in_s fault_in;
	loop_cfg_s loop_cfg;
	int bad_count, checks;
	// host model drives both ports; the serial one is idle outside frames
	resolver_converter_config_regs uut (.clk, .reset, .mode_sel_0, .mode_sel_1, .cs_n, .rd_n,
		.write_strobe_frame_sync, .soe_n, .sample_n, .db_in, .db_out, .db_oe_n,
		.sclk, .sdi, .sdo, .out_res_sel_lo, .out_res_sel_hi, .fault_in, .pos_in,
		.pos_hyst, .loop_cfg, .exc_phase, .loop_restart, .signal_degrade_flag_n,
		.tracking_loss_flag_n);
	host_port_model host (.clk, .db_out, .sdo, .cs_n, .rd_n, .write_strobe_frame_sync, .db_in,
		.mode_sel_0, .mode_sel_1, .soe_n, .sclk, .sdi);
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// compare and count
	task chk(input string n, input logic [15:0] g, e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task rd(input logic [7:0] a, e);
		host.get(a, d);
		chk("readback", 16'(d), 16'(e));
	endtask
	task report_and_stop();
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// hang guard, several times the expected run
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		report_and_stop();
	end
	// main sequence
	initial begin
		reset = 1'b1;
		sample_n = 1'b1;
		out_res_sel_lo = 1'b0;
		out_res_sel_hi = 1'b1;
		fault_in = '0;
		pos_in = '0;
		bad_count = 0;
		checks = 0;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("settings", 16'(loop_cfg), 16'({`RST_FCW, 2'b11, RES_16, RES_12}));
		host.mode(1'b1);
		rd(8'h92, 8'h7e);
		rd(8'h91, {1'b0, `RST_FCW});
		// 12-bit output: one lsb is 16 counts, a step of one is held
		pos_in <= 16'h0010;
		repeat (3) @(posedge clk);
		chk("hold", pos_hyst, 16'h0000);
		pos_in <= 16'h0035;
		repeat (3) @(posedge clk);
		chk("follow", pos_hyst, 16'h0030);
		// odd-parity word, then two data bytes on one address
		host.put(8'h91);
		host.put(8'h15);
		rd(8'h91, 8'h15);
		host.put(8'h91);
		host.put(8'h04);
		host.put(8'h50);
		rd(8'h91, 8'h50);
		for (int i = 0; i < 4; i++) begin
			v = {2'b01, 2'(i), 2'(i), 2'(3 - i)};
			host.put(8'h92);
			host.put(v);
			rd(8'h92, v);
			chk("control", 16'(loop_cfg), 16'({7'h50, v[5:4], v[2], v[3], v[0], v[1]}));
		end
		// normal mode: pins rule, writes ignored
		out_res_sel_hi <= 1'b0;
		host.mode(1'b0);
		out_res_sel_lo <= 1'b1;
		host.put(8'h91);
		host.put(8'h22);
		chk("pin res", 16'(loop_cfg.out_res), 16'(RES_14));
		out_res_sel_lo <= 1'b0;
		host.mode(1'b1);
		rd(8'h91, 8'h50);
		// serial port: address, data, then the address again to read back
		host.port(1'b1);
		host.xfer(8'h91, v);
		host.xfer(8'h33, v);
		host.xfer(8'h91, v);
		chk("serial", 16'(v), 16'h0033);
		chk("serial fcw", 16'(loop_cfg.freq_control_word), 16'h0033);
		host.port(1'b0);
		// each detector: pin, register bit, clear by sample after read
		for (int k = 0; k < 7; k++) begin
			fault_in <= fault_in_s'(7'(1 << k));
			@(posedge clk);
			fault_in <= '0;
			repeat (3) @(posedge clk);
			chk("pins", 16'({signal_degrade_flag_n, tracking_loss_flag_n}),
				16'(k < 3 ? 2'b10 : 2'b01));
			rd(8'hff, 8'(2 << k));
			sample_n <= 1'b0;
			@(posedge clk);
			sample_n <= 1'b1;
			repeat (4) @(posedge clk);
			chk("cleared", 16'({signal_degrade_flag_n, tracking_loss_flag_n}), 16'h3);
		end
		// 360 degree range: a signal loss is followed by a software reset
		host.put(8'h92);
		host.put(8'h4c);
		fault_in <= fault_in_s'(7'h20);
		@(posedge clk);
		fault_in <= '0;
		host.put(8'hf0);
		repeat (3) @(posedge clk);
		chk("soft", 16'({signal_degrade_flag_n, tracking_loss_flag_n}), 16'h3);
		chk("range", 16'(loop_cfg.lock_range_narrow), 16'h0000);
		rd(8'h92, 8'h4c);
		rd(8'hff, 8'h00);
		report_and_stop();
	end
endmodule
